/* File: mtg_params.svh */
// Register offsets, field positions, reset values and error codes
`ifndef MTG_PARAMS_SVH
`define MTG_PARAMS_SVH

// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define MTG_OFF_BEG_COUNT      12'h0C8
`define MTG_OFF_RDATA_WIDTH    12'h0DC
`define MTG_OFF_ERROR_REPORT   12'h0EC
`define MTG_OFF_WIDTH_RATIO    12'h0F0
`define MTG_OFF_SEQ_INCR       12'h100
`define MTG_OFF_START_ADDR     12'h140
`define MTG_OFF_ADDR_MODE      12'h180
`define MTG_OFF_PASSED         12'h1C0
`define MTG_OFF_FAILED         12'h1C4
`define MTG_OFF_FAIL_CNT_LO    12'h1C8
`define MTG_OFF_FAIL_CNT_HI    12'h1CC
`define MTG_OFF_FIRST_FAIL_LO  12'h1D0
`define MTG_OFF_FIRST_FAIL_HI  12'h1D4
`define MTG_OFF_TOTAL_LO       12'h1D8
`define MTG_OFF_TOTAL_HI       12'h1DC
`define MTG_OFF_COMPLETE       12'h1E0
`define MTG_OFF_INVERT         12'h1E4
`define MTG_OFF_REREAD_EN      12'h1EC
`define MTG_OFF_BE_COMPARE     12'h1F0
`define MTG_OFF_DG_COUNT       12'h1F8
`define MTG_OFF_BEG_COUNT_ALT  12'h1FC
`define MTG_OFF_RDW_ALT        12'h200
// Block-local registers
`define MTG_OFF_RUN_CTRL       12'h010
`define MTG_OFF_BURST_LEN      12'h01C
`define MTG_OFF_REREAD_DATA    12'h740

// ---------------------------------------------------------------------
// Field counts and reset values
// ---------------------------------------------------------------------
`define MTG_NUM_FIELDS         6
`define MTG_NUM_START_REGS     12
`define MTG_RST_SEQ_INCR       8'h01
`define MTG_RST_MODE           2'h2
`define MTG_RST_BURST_LEN      7'h01
`define MTG_RUN_START_BIT      0
`define MTG_ERR_INCR_LT_BURST  32'h0000_0001
`define MTG_ERR_ZERO_BURST     32'h0000_0002

`endif

/* File: mtg_pkg.sv */
// Types shared by the traffic generator register block
package mtg_pkg;

  // Address field mode
  typedef enum logic [1:0] {
    MTG_MODE_FIXED  = 2'h0,
    MTG_MODE_RANDOM = 2'h1,
    MTG_MODE_SEQ    = 2'h2,
    MTG_MODE_UNUSED = 2'h3
  } mtg_mode_t;

  // One read beat returned from the memory port
  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
    logic [31:0] data;
    logic [31:0] expect_data;
    logic [3:0]  byte_en;
  } mtg_rsp_t;

  // Run sequencing states
  typedef enum logic [3:0] {
    MTG_ST_IDLE   = 4'b0001,
    MTG_ST_RUN    = 4'b0010,
    MTG_ST_REREAD = 4'b0100,
    MTG_ST_DONE   = 4'b1000
  } mtg_state_t;

endpackage

/* File: mtg_checker.sv */
// Per-byte read data compare with optional byte-enable aware mode
`timescale 1ns/10ps
`default_nettype none

module mtg_checker
  import mtg_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input  wire logic [DATA_W-1:0]   rdata,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [DATA_W/8-1:0] byte_en,
  input  wire logic                be_mode,
  output logic      [DATA_W-1:0]   per_bit_ok,
  output logic                     mismatch
);

  // ---------------------------------------------------------------
  // Byte lanes
  // ---------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < DATA_W/8; b = b + 1) begin : g_lane
      logic [7:0] ref_byte;
      // Disabled lanes expect the inverted pattern in compare mode
      assign ref_byte = (be_mode && !byte_en[b]) ? ~wdata[b*8 +: 8]
                                                 : wdata[b*8 +: 8];
      assign per_bit_ok[b*8 +: 8] = ~(rdata[b*8 +: 8] ^ ref_byte);
    end
  endgenerate

  assign mismatch = ~&per_bit_ok;

endmodule
`default_nettype wire

/* File: mtg_csr.sv */
// Register block of the memory test traffic generator
`timescale 1ns/10ps
`default_nettype none
`include "mtg_params.svh"

module mtg_csr
  import mtg_pkg::*;
#(
  parameter logic [4:0]  NUM_BYTE_EN_GEN = 5'h01,
  parameter logic [4:0]  NUM_DATA_GEN    = 5'h01,
  parameter logic [3:0]  WIDTH_RATIO     = 4'h4,
  parameter int          DATA_W          = 32,
  parameter logic [63:0] ADDR_SPACE      = 64'h0000_0000_0100_0000
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Generator side
  input  wire mtg_rsp_t            rsp,
  input  wire logic                issue_read,
  input  wire logic                stages_done,
  input  wire logic [63:0]         cur_addr,
  input  wire logic [6:0]          req_burst_len,
  output logic                     run_active,
  output logic                     invert_write_pattern,
  output logic                     targeted_reread_mode,
  output logic                     byte_enable_compare_mode,
  output logic                     reread_req,
  output logic [63:0]              reread_addr,
  output logic [6:0]               clipped_burst_len,
  output logic [15:0]              field_mode_flat,
  output logic [47:0]              field_incr_flat,
  output logic [383:0]             field_start_flat,
  output logic [DATA_W-1:0]        per_bit_compare_result
);

  // ---------------------------------------------------------------
  // Configuration storage
  // ---------------------------------------------------------------
  logic [7:0]  field_sequential_increment [`MTG_NUM_FIELDS];
  logic [31:0] read_field_start_address   [`MTG_NUM_START_REGS];
  logic [1:0]  read_field_address_mode    [`MTG_NUM_FIELDS];
  logic [6:0]  configured_burst_length;
  logic        test_passed_flag;
  logic        test_failed_flag;
  logic        run_complete_flag;
  logic [63:0] failed_read_count;
  logic [63:0] first_failure_address;
  logic [63:0] total_reads;
  logic        first_seen;
  logic [31:0] reread_data;
  logic [31:0] config_error_report;
  logic        mismatch;
  mtg_state_t  state;
  mtg_state_t  next_state;

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        start_pulse;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign start_pulse = wr_fire && aw_addr == `MTG_OFF_RUN_CTRL &&
                       w_strb[0] && w_data[`MTG_RUN_START_BIT];

  // Writable registers; narrow fields live in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `MTG_NUM_FIELDS; i++) begin
        field_sequential_increment[i] <= `MTG_RST_SEQ_INCR;
        read_field_address_mode[i]    <= `MTG_RST_MODE;
      end
      for (int i = 0; i < `MTG_NUM_START_REGS; i++) begin
        read_field_start_address[i] <= 32'h0000_0000;
      end
      configured_burst_length  <= `MTG_RST_BURST_LEN;
      invert_write_pattern     <= 1'b0;
      targeted_reread_mode     <= 1'b0;
      byte_enable_compare_mode <= 1'b0;
    end else if (wr_fire) begin
      for (int i = 0; i < `MTG_NUM_FIELDS; i++) begin
        if (aw_addr == `MTG_OFF_SEQ_INCR + 12'(4*i) && w_strb[0])
          field_sequential_increment[i] <= w_data[7:0];
        if (aw_addr == `MTG_OFF_ADDR_MODE + 12'(4*i) && w_strb[0])
          read_field_address_mode[i] <= w_data[1:0];
      end
      for (int i = 0; i < `MTG_NUM_START_REGS; i++) begin
        if (aw_addr == `MTG_OFF_START_ADDR + 12'(4*i)) begin
          for (int k = 0; k < 4; k++) begin
            if (w_strb[k])
              read_field_start_address[i][k*8 +: 8] <= w_data[k*8 +: 8];
          end
        end
      end
      if (aw_addr == `MTG_OFF_BURST_LEN && w_strb[0])
        configured_burst_length <= w_data[6:0];
      if (aw_addr == `MTG_OFF_INVERT && w_strb[0])
        invert_write_pattern <= w_data[0];
      if (aw_addr == `MTG_OFF_REREAD_EN && w_strb[0])
        targeted_reread_mode <= w_data[0];
      if (aw_addr == `MTG_OFF_BE_COMPARE && w_strb[0])
        byte_enable_compare_mode <= w_data[0];
    end
  end

  // ---------------------------------------------------------------
  // Flattened views for the address generators
  // ---------------------------------------------------------------
  genvar f;
  generate
    for (f = 0; f < `MTG_NUM_FIELDS; f = f + 1) begin : g_field
      // Increment only meaningful in sequential mode
      assign field_incr_flat[f*8 +: 8] =
        (read_field_address_mode[f] == MTG_MODE_SEQ) ?
        field_sequential_increment[f] : 8'h00;
      assign field_mode_flat[f*2 +: 2] = read_field_address_mode[f];
      // Low word first, high word second
      assign field_start_flat[f*64 +: 64] =
        {read_field_start_address[2*f+1],
         read_field_start_address[2*f]};
    end
  endgenerate
  assign field_mode_flat[15:12] = 4'h0;

  // Illegal configuration codes
  always_comb begin
    config_error_report = 32'h0000_0000;
    if (field_sequential_increment[0] < {1'b0, configured_burst_length} &&
        read_field_address_mode[0] == MTG_MODE_SEQ)
      config_error_report = config_error_report |
                            `MTG_ERR_INCR_LT_BURST;
    if (configured_burst_length == 7'h00)
      config_error_report = config_error_report | `MTG_ERR_ZERO_BURST;
  end

  // Clip a burst that would run past the address space
  always_comb begin
    if (cur_addr + 64'(req_burst_len) > ADDR_SPACE) begin
      clipped_burst_len = 7'(ADDR_SPACE - cur_addr);
    end else begin
      clipped_burst_len = req_burst_len;
    end
  end

  // ---------------------------------------------------------------
  // Read data check
  // ---------------------------------------------------------------
  mtg_checker #(.DATA_W(DATA_W)) u_checker (
    .rdata      (rsp.data),
    .wdata      (rsp.expect_data),
    .byte_en    (rsp.byte_en),
    .be_mode    (byte_enable_compare_mode),
    .per_bit_ok (per_bit_compare_result),
    .mismatch   (mismatch)
  );

  // ---------------------------------------------------------------
  // Run sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      MTG_ST_IDLE: begin
        if (start_pulse) next_state = MTG_ST_RUN;
      end
      MTG_ST_RUN: begin
        if (stages_done)
          next_state = (targeted_reread_mode && first_seen) ?
                       MTG_ST_REREAD : MTG_ST_DONE;
      end
      MTG_ST_REREAD: begin
        if (rsp.valid) next_state = MTG_ST_DONE;
      end
      MTG_ST_DONE: begin
        if (start_pulse) next_state = MTG_ST_RUN;
      end
      default: next_state = MTG_ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state <= MTG_ST_IDLE;
    else          state <= next_state;
  end

  assign run_active  = state == MTG_ST_RUN;
  assign reread_req  = state == MTG_ST_REREAD;
  assign reread_addr = first_failure_address;

  // Counters and first failure; frozen outside a run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      failed_read_count     <= 64'h0;
      total_reads           <= 64'h0;
      first_failure_address <= 64'h0;
      first_seen            <= 1'b0;
    end else if (start_pulse && state != MTG_ST_RUN) begin
      failed_read_count     <= 64'h0;
      total_reads           <= 64'h0;
      first_failure_address <= 64'h0;
      first_seen            <= 1'b0;
    end else if (run_active && rsp.valid) begin
      total_reads <= total_reads + 64'h1;
      if (mismatch) begin
        failed_read_count <= failed_read_count + 64'h1;
        if (!first_seen) begin
          first_failure_address <= rsp.addr;
          first_seen            <= 1'b1;
        end
      end
    end
  end

  // Data returned by the second read of the failing address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reread_data <= 32'h0000_0000;
    end else if (reread_req && rsp.valid) begin
      reread_data <= rsp.data;
    end
  end

  // Verdict flags, exclusive by construction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_passed_flag  <= 1'b0;
      test_failed_flag  <= 1'b0;
      run_complete_flag <= 1'b0;
    end else if (start_pulse && state != MTG_ST_RUN) begin
      test_passed_flag  <= 1'b0;
      test_failed_flag  <= 1'b0;
      run_complete_flag <= 1'b0;
    end else if (next_state == MTG_ST_DONE && state != MTG_ST_DONE) begin
      run_complete_flag <= 1'b1;
      test_passed_flag  <= !first_seen;
      test_failed_flag  <= first_seen;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;
  logic        next_rerr;

  assign s_axi_arready = !s_axi_rvalid;

  // Address decode; unmapped reads answer zero with SLVERR
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    if (s_axi_araddr == `MTG_OFF_BEG_COUNT ||
        s_axi_araddr == `MTG_OFF_BEG_COUNT_ALT) begin
      next_rdata = {27'h0, NUM_BYTE_EN_GEN};
    end else if (s_axi_araddr == `MTG_OFF_DG_COUNT) begin
      next_rdata = {27'h0, NUM_DATA_GEN};
    end else if (s_axi_araddr == `MTG_OFF_RDATA_WIDTH ||
                 s_axi_araddr == `MTG_OFF_RDW_ALT) begin
      next_rdata = 32'(DATA_W);
    end else if (s_axi_araddr == `MTG_OFF_ERROR_REPORT) begin
      next_rdata = config_error_report;
    end else if (s_axi_araddr == `MTG_OFF_WIDTH_RATIO) begin
      next_rdata = {28'h0, WIDTH_RATIO};
    end else if (s_axi_araddr >= `MTG_OFF_SEQ_INCR &&
                 s_axi_araddr <  `MTG_OFF_SEQ_INCR + 12'h018 &&
                 s_axi_araddr[1:0] == 2'h0) begin
      next_rdata = {24'h0, field_sequential_increment[
                   3'(s_axi_araddr[4:2])]};
    end else if (s_axi_araddr >= `MTG_OFF_START_ADDR &&
                 s_axi_araddr <  `MTG_OFF_START_ADDR + 12'h030 &&
                 s_axi_araddr[1:0] == 2'h0) begin
      next_rdata = read_field_start_address[4'(s_axi_araddr[5:2])];
    end else if (s_axi_araddr >= `MTG_OFF_ADDR_MODE &&
                 s_axi_araddr <  `MTG_OFF_ADDR_MODE + 12'h018 &&
                 s_axi_araddr[1:0] == 2'h0) begin
      next_rdata = {30'h0, read_field_address_mode[
                   3'(s_axi_araddr[4:2])]};
    end else if (s_axi_araddr == `MTG_OFF_PASSED) begin
      next_rdata = {31'h0, test_passed_flag};
    end else if (s_axi_araddr == `MTG_OFF_FAILED) begin
      next_rdata = {31'h0, test_failed_flag};
    end else if (s_axi_araddr == `MTG_OFF_FAIL_CNT_LO) begin
      next_rdata = failed_read_count[31:0];
    end else if (s_axi_araddr == `MTG_OFF_FAIL_CNT_HI) begin
      next_rdata = failed_read_count[63:32];
    end else if (s_axi_araddr == `MTG_OFF_FIRST_FAIL_LO) begin
      next_rdata = first_failure_address[31:0];
    end else if (s_axi_araddr == `MTG_OFF_FIRST_FAIL_HI) begin
      next_rdata = first_failure_address[63:32];
    end else if (s_axi_araddr == `MTG_OFF_TOTAL_LO) begin
      next_rdata = total_reads[31:0];
    end else if (s_axi_araddr == `MTG_OFF_TOTAL_HI) begin
      next_rdata = total_reads[63:32];
    end else if (s_axi_araddr == `MTG_OFF_COMPLETE) begin
      next_rdata = {31'h0, run_complete_flag};
    end else if (s_axi_araddr == `MTG_OFF_INVERT) begin
      next_rdata = {31'h0, invert_write_pattern};
    end else if (s_axi_araddr == `MTG_OFF_REREAD_EN) begin
      next_rdata = {31'h0, targeted_reread_mode};
    end else if (s_axi_araddr == `MTG_OFF_BE_COMPARE) begin
      next_rdata = {31'h0, byte_enable_compare_mode};
    end else if (s_axi_araddr == `MTG_OFF_BURST_LEN) begin
      next_rdata = {25'h0, configured_burst_length};
    end else if (s_axi_araddr == `MTG_OFF_RUN_CTRL) begin
      next_rdata = {31'h0, run_active};
    end else if (s_axi_araddr == `MTG_OFF_REREAD_DATA) begin
      next_rdata = reread_data;
    end else begin
      next_rerr = 1'b1;
    end
  end

  // Read data registered; one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rerr ? 2'h2 : 2'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: mtg_csr_assertions.sv */
// Concurrent checks on the traffic generator register block ports
`timescale 1ns/10ps
`default_nettype none
module mtg_csr_assertions
  import mtg_pkg::*;
#(
  parameter int          DATA_W     = 32,
  parameter logic [63:0] ADDR_SPACE = 64'h0000_0000_0100_0000
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_wready,
  input wire mtg_rsp_t          rsp,
  input wire logic              stages_done,
  input wire logic [63:0]       cur_addr,
  input wire logic [6:0]        req_burst_len,
  input wire logic              run_active,
  input wire logic              targeted_reread_mode,
  input wire logic              byte_enable_compare_mode,
  input wire logic              reread_req,
  input wire logic [63:0]       reread_addr,
  input wire logic [6:0]        clipped_burst_len,
  input wire logic [15:0]       field_mode_flat,
  input wire logic [47:0]       field_incr_flat,
  input wire logic [DATA_W-1:0] per_bit_compare_result
);
  // Disabled bytes must match inverted data in compare mode
  logic [31:0] keep;
  assign keep = byte_enable_compare_mode ? {{8{rsp.byte_en[3]}},
    {8{rsp.byte_en[2]}}, {8{rsp.byte_en[1]}}, {8{rsp.byte_en[0]}}} : '1;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_clip_exact: assert property (
    cur_addr + 64'(req_burst_len) <= ADDR_SPACE
    |-> clipped_burst_len == req_burst_len) else $error("burst clipped");
  a_clip_limit: assert property (
    cur_addr < ADDR_SPACE && cur_addr + 64'(req_burst_len) > ADDR_SPACE
    |-> 64'(clipped_burst_len) == ADDR_SPACE - cur_addr)
    else $error("burst not clipped");
  a_incr_seq_only: assert property (
    field_mode_flat[1:0] != 2'h2 |-> field_incr_flat[7:0] == 8'h00)
    else $error("increment outside sequential mode");
  a_run_ends: assert property (
    run_active && stages_done && !targeted_reread_mode |=> !run_active)
    else $error("run did not end");
  a_reread_start: assert property (
    $rose(reread_req) |-> $past(run_active) && $past(stages_done)
    && targeted_reread_mode) else $error("reread without mode");
  a_reread_exit: assert property (
    reread_req && rsp.valid |=> !reread_req) else $error("reread stuck");
  a_compare_bits: assert property (
    run_active && rsp.valid |-> per_bit_compare_result
    == DATA_W'(~(rsp.data ^ rsp.expect_data ^ ~keep)))
    else $error("compare result wrong");
  a_status_hold: assert property (
    !run_active && !reread_req && s_axi_wready |=> $stable(reread_addr))
    else $error("first failure address moved");
endmodule
bind mtg_csr mtg_csr_assertions #(.DATA_W(DATA_W), .ADDR_SPACE(ADDR_SPACE))
  i_mtg_csr_assertions (.*);
`default_nettype wire

/* File: mtg_mem_model.sv */
// Memory port model returning read beats to the register block
`timescale 1ns/10ps
`default_nettype none
module mtg_mem_model
  import mtg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        go,
  input  wire mtg_rsp_t    beat,
  input  wire logic        reread_req,
  input  wire logic [63:0] reread_addr,
  input  wire logic [31:0] reread_data,
  output mtg_rsp_t         rsp
);
  // One beat per request; idle data flips each cycle, so a stale value cannot match on two idle cycles in a row
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp <= '0;
    end else if (go) begin
      rsp <= beat;
    end else if (reread_req && !rsp.valid) begin
      rsp <= '{1'b1, reread_addr, reread_data, reread_data, 4'hF};
    end else begin
      rsp.valid <= 1'b0;
      rsp.data  <= ~rsp.data;
    end
  end
endmodule
`default_nettype wire

/* File: mtg_csr_tb.sv */
// Self-checking bench of the traffic generator register block
`timescale 1ns/10ps
`default_nettype none
`define MTG_CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module mtg_csr_tb
  import mtg_pkg::*;
();
  localparam logic [63:0] SPACE = 64'h0000_0000_0000_1000;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, issue_read, stages_done, reread_req;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, run_active, invert_write_pattern;
  logic targeted_reread_mode, byte_enable_compare_mode;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val, per_bit_compare_result;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [63:0] cur_addr, reread_addr;
  logic [6:0] req_burst_len, clipped_burst_len;
  logic [15:0] field_mode_flat;
  logic [47:0] field_incr_flat;
  logic [383:0] field_start_flat;
  mtg_rsp_t rsp, beat;
  int fails, checks;
  mtg_csr #(.NUM_BYTE_EN_GEN(5'h03), .NUM_DATA_GEN(5'h05),
    .WIDTH_RATIO(4'h2), .ADDR_SPACE(SPACE)) i_mtg_csr (.*);
  mtg_mem_model i_mtg_mem_model (.aclk, .aresetn, .go(issue_read), .beat,
    .reread_req, .reread_addr, .reread_data(32'hC0DE_5A5A), .rsp);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Bus tasks hold each channel until its own ready is sampled
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta = 1'b0;
    logic td = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ta && td)) begin
      @(posedge aclk);
      ta = ta | s_axi_awready;
      td = td | s_axi_wready;
      if (ta) s_axi_awvalid <= 1'b0;
      if (td) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    {rd_val, rd_resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    `MTG_CHK(rd_val, e)
  endtask
  // One returned beat, with a gap cycle after it
  task automatic send(input logic [63:0] a, input logic [31:0] d, x,
                      input logic [3:0] be);
    @(posedge aclk);
    {issue_read, beat} <= {1'b1, 1'b1, a, d, x, be};
    @(posedge aclk);
    issue_read <= 1'b0;
  endtask
  task automatic finish_run();
    @(posedge aclk);
    stages_done <= 1'b1;
    @(posedge aclk);
    stages_done <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic t_ident();
    chk(12'h0C8, 32'h3);
    chk(12'h1FC, 32'h3);
    chk(12'h1F8, 32'h5);
    chk(12'h0DC, 32'h20);
    chk(12'h200, 32'h20);
    wr(12'h0F0, 32'hF);
    chk(12'h0F0, 32'h2);
    rd(12'h7FC);
    `MTG_CHK(rd_resp, 2'h2)
    $display("t_ident finished");
  endtask
  task automatic t_fields();
    chk(12'h184, 32'h2);
    chk(12'h0EC, 32'h0);
    wr(12'h01C, 32'h8);
    chk(12'h0EC, 32'h1);
    wr(12'h100, 32'h8);
    chk(12'h0EC, 32'h0);
    wr(12'h01C, 32'h0);
    chk(12'h0EC, 32'h2);
    for (int m = 0; m < 4; m++) begin
      wr(12'h180, 32'(m));
      chk(12'h180, 32'(m));
      `MTG_CHK(field_mode_flat[1:0], 2'(m))
      `MTG_CHK(field_incr_flat[7:0], (m == 2) ? 8'h08 : 8'h00)
    end
    wr(12'h148, 32'h1111_2222);
    wr(12'h14C, 32'hAAAA_5555);
    chk(12'h14C, 32'hAAAA_5555);
    `MTG_CHK(field_start_flat[127:64], 64'hAAAA_5555_1111_2222)
    $display("t_fields finished");
  endtask
  task automatic t_ctrl();
    wr(12'h1E4, 32'h1);
    `MTG_CHK(invert_write_pattern, 1'b1)
    wr(12'h1F0, 32'h1);
    chk(12'h1F0, 32'h1);
    {cur_addr, req_burst_len} <= {SPACE - 64'h3, 7'h07};
    repeat (2) @(posedge aclk);
    `MTG_CHK(clipped_burst_len, 7'h03)
    $display("t_ctrl finished");
  endtask
  // Last beat passes only under byte-enable aware compare
  task automatic t_fail();
    wr(12'h010, 32'h1);
    send(64'h10, 32'h5A, 32'h5A, 4'hF);
    send(64'h0000_0001_0000_0020, 32'h1, 32'h3, 4'hF);
    send(64'h30, 32'h0, 32'hFF, 4'hF);
    send(64'h40, 32'hFFFF_FFFF, 32'hFF00_0000, 4'h8);
    finish_run();
    `MTG_CHK(run_active, 1'b0)
    chk(12'h1D8, 32'h4);
    chk(12'h1C8, 32'h2);
    chk(12'h1CC, 32'h0);
    chk(12'h1D0, 32'h20);
    chk(12'h1D4, 32'h1);
    chk(12'h1C4, 32'h1);
    chk(12'h1C0, 32'h0);
    send(64'h50, 32'h0, 32'h1, 4'hF);
    chk(12'h1C8, 32'h2);
    chk(12'h1E0, 32'h1);
    $display("t_fail finished");
  endtask
  task automatic t_pass();
    wr(12'h010, 32'h1);
    `MTG_CHK(run_active, 1'b1)
    send(64'h60, 32'h77, 32'h77, 4'hF);
    finish_run();
    chk(12'h1C0, 32'h1);
    chk(12'h1C4, 32'h0);
    chk(12'h1C8, 32'h0);
    chk(12'h1D8, 32'h1);
    $display("t_pass finished");
  endtask
  task automatic t_reread();
    wr(12'h1EC, 32'h1);
    `MTG_CHK(targeted_reread_mode, 1'b1)
    wr(12'h010, 32'h1);
    send(64'h70, 32'h1, 32'h2, 4'hF);
    finish_run();
    `MTG_CHK(reread_addr, 64'h70)
    chk(12'h740, 32'hC0DE_5A5A);
    chk(12'h1E0, 32'h1);
    $display("t_reread finished");
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // A hung handshake ends the run through the same verdict
  initial begin
    #400000;
    fails++;
    results();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, issue_read, stages_done, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, cur_addr, beat, fails, checks} = '0;
    {s_axi_wstrb, req_burst_len} = {4'hF, 7'h01};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_ident();
    t_fields();
    t_ctrl();
    t_fail();
    t_pass();
    t_reread();
    results();
  end
endmodule
`default_nettype wire
